// ===== design/cong_pkg.sv
// Purpose: Shared constants and types for the congestion-window block
// Assumes: Ten output ports, buffer counts fit in 10 bits
// Notes: Threshold sets indexed by buffer memory size code
`default_nettype none
package cong_pkg;
    localparam int NPORT = 10;
    localparam int CW = 10;
    localparam int QW = 10;
    // Buffer memory size codes
    localparam logic [1:0] MEM_128K = 2'h0;
    localparam logic [1:0] MEM_256K = 2'h1;
    localparam logic [1:0] MEM_512K = 2'h2;
    localparam logic [1:0] MEM_1M = 2'h3;
    // Fixed constants
    localparam logic [CW-1:0] STARVE_LEVEL = 10'h009;
    localparam logic [CW-1:0] RESPONSE_BUFS = 10'h002;
    localparam logic [CW-1:0] RESUME_OFFSET = 10'h014;
    // Per-size sets: pool, ceiling, floor offset D, reserve C, rmax
    localparam logic [CW-1:0] POOL_128K = 10'h040;
    localparam logic [CW-1:0] CEIL_128K = 10'h01d;
    localparam logic [CW-1:0] D_128K = 10'h00f;
    localparam logic [CW-1:0] C_128K = 10'h00a;
    localparam logic [CW-1:0] RMAX_128K = 10'h001;
    localparam logic [CW-1:0] POOL_256K = 10'h095;
    localparam logic [CW-1:0] CEIL_256K = 10'h02e;
    localparam logic [CW-1:0] D_256K = 10'h01c;
    localparam logic [CW-1:0] C_256K = 10'h00a;
    localparam logic [CW-1:0] RMAX_256K = 10'h004;
    localparam logic [CW-1:0] POOL_512K = 10'h140;
    localparam logic [CW-1:0] CEIL_512K = 10'h04c;
    localparam logic [CW-1:0] D_512K = 10'h025;
    localparam logic [CW-1:0] C_512K = 10'h014;
    localparam logic [CW-1:0] RMAX_512K = 10'h006;
    localparam logic [CW-1:0] POOL_1M = 10'h295;
    localparam logic [CW-1:0] CEIL_1M = 10'h066;
    localparam logic [CW-1:0] D_1M = 10'h025;
    localparam logic [CW-1:0] C_1M = 10'h01e;
    localparam logic [CW-1:0] RMAX_1M = 10'h008;

    typedef struct packed {
        logic [CW-1:0] buffer_pool_size;
        logic [CW-1:0] pause_threshold_ceiling;
        logic [CW-1:0] pause_offset;
        logic [CW-1:0] reserve;
        logic [CW-1:0] rmax;
    } thresh_t;

    typedef struct packed {
        logic valid;
        logic [NPORT-1:0] src;
        logic [NPORT-1:0] dst;
        logic bcast;
    } enq_t;

    typedef enum logic [1:0] {
        ST_LOAD = 2'b01,
        ST_RUN = 2'b10
    } cfg_state_t;
endpackage
`default_nettype wire

// ===== design/switch_congestion_thresholds.sv
// Purpose: Pause window, reservation and broadcast storm logic of a switch buffer manager
// Assumes: Queue lengths and free count arrive synchronous to CLK
// Notes: Threshold set latched from MEM_SIZE at reset release
//
// Function
// [R1] Pause entry never below total reservation
// [R2] Size thresholds for two-buffer response per port
// [R3] Per-port reservation from queue shortfall
// [R4] Total reservation sums ports zero to nine
// [R5] Virtual free equals free minus reserve
// [R6] Three pause-entry conditions per source port
// [R7] Leave pause when virtual free exceeds resume
// [R8] Reserve between starvation level and offset
// [R9] Pause offset 28 for 256KB memory
// [R10] Resume is half of pool plus ceiling minus 20
// [R11] 256KB set: 46, 38, 98, 4
// [R12] 512KB set: 76, 57, 198, 6 (code leaves pause at free count 209, not 198)
// [R13] Broadcast to paused destination pauses source
// [R14] Drop broadcasts while any drop window active
// [R15] Pause event always sends maximum pause frame
// [R16] Half-duplex paused port collides non-local packets
// [R17] Threshold set chosen at reset, then fixed
// [R18] Reservations recomputed every cycle
`default_nettype none
module switch_congestion_thresholds
    import cong_pkg::*;
#(
    parameter int PORTS = NPORT
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [1:0] MEM_SIZE,
    input wire logic [PORTS*QW-1:0] QUEUE_LEN,
    input wire logic [CW-1:0] FREE_COUNT,
    input wire enq_t ENQ,
    input wire logic [PORTS-1:0] HALF_DUPLEX,
    input wire logic [PORTS-1:0] NON_LOCAL,
    input wire logic [PORTS-1:0] DROP_ENABLE,
    output logic [PORTS-1:0] PAUSE_WINDOW,
    output logic [PORTS-1:0] PAUSE_FRAME_REQ,
    output logic [15:0] PAUSE_TIME,
    output logic [PORTS-1:0] FORCE_COLLISION,
    output logic [PORTS-1:0] CONGESTED,
    output logic BCAST_DROP,
    output logic [CW-1:0] RESERVE_TOTAL,
    output logic [CW-1:0] VIRTUAL_FREE
);
    localparam logic [15:0] MAX_PAUSE = 16'hffff;

    // ----------------------------------------
    // Threshold selection
    // ----------------------------------------
    function automatic thresh_t pick_set(input logic [1:0] sz);
        thresh_t t;
        t = '{POOL_128K, CEIL_128K, D_128K, C_128K, RMAX_128K};
        case (sz)
            MEM_128K: t = '{POOL_128K, CEIL_128K, D_128K, C_128K, RMAX_128K};
            MEM_256K: t = '{POOL_256K, CEIL_256K, D_256K, C_256K, RMAX_256K}; // [R9] [R11]
            MEM_512K: t = '{POOL_512K, CEIL_512K, D_512K, C_512K, RMAX_512K}; // [R12]
            MEM_1M: t = '{POOL_1M, CEIL_1M, D_1M, C_1M, RMAX_1M};
            default: t = '{POOL_128K, CEIL_128K, D_128K, C_128K, RMAX_128K};
        endcase
        return t;
    endfunction

    thresh_t ts;
    cfg_state_t cfg_state;
    logic [CW-1:0] resume_threshold;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            cfg_state <= ST_LOAD;
            ts <= '0;
        end else if (cfg_state == ST_LOAD) begin
            ts <= pick_set(MEM_SIZE); // [R17]
            cfg_state <= ST_RUN;
        end
    end

    // Ceiling already holds per-port response allowance of 2 buffers
    wire [CW:0] resume_sum = {1'b0, ts.buffer_pool_size} + {1'b0, ts.pause_threshold_ceiling}; // [R2]
    wire [CW:0] resume_half = (resume_sum - {1'b0, RESUME_OFFSET}) >> 1; // [R10]
    // Reserve held strictly between starvation level and pause offset
    wire reserve_ok = (ts.reserve > STARVE_LEVEL) && (ts.reserve < ts.pause_offset); // [R8]
    wire [CW-1:0] reserve_c = reserve_ok ? ts.reserve : STARVE_LEVEL + 10'h001; // [R8]
    wire [CW-1:0] pause_floor = ts.pause_offset; // [R9]

    always_ff @(posedge CLK) begin
        if (SRST) begin
            resume_threshold <= '0;
        end else begin
            resume_threshold <= resume_half[CW-1:0];
        end
    end

    // ----------------------------------------
    // Reservation counts
    // ----------------------------------------
    logic [CW-1:0] resv [PORTS];
    logic [PORTS-1:0] resv_zero;

    genvar g;
    generate
        for (g = 0; g < PORTS; g++) begin : g_res
            wire [QW-1:0] q = QUEUE_LEN[g*QW +: QW];
            assign resv[g] = (q >= ts.rmax) ? '0 : ts.rmax - q; // [R3] [R18]
            assign resv_zero[g] = (resv[g] == '0);
        end
    endgenerate

    logic [CW+3:0] psi_wide;
    always_comb begin
        psi_wide = '0;
        for (int i = 0; i < PORTS; i++) begin
            psi_wide = psi_wide + {4'h0, resv[i]}; // [R4] [R18]
        end
    end
    wire [CW-1:0] psi = psi_wide[CW-1:0];

    // ----------------------------------------
    // Virtual free and pause windows
    // ----------------------------------------
    wire [CW-1:0] omega = (FREE_COUNT <= reserve_c) ? '0 : FREE_COUNT - reserve_c; // [R5]
    wire [CW-1:0] entry_level = (psi > pause_floor) ? psi : pause_floor; // [R1]
    wire any_paused = |PAUSE_WINDOW;
    wire [PORTS-1:0] dst_paused = ENQ.dst & PAUSE_WINDOW;
    wire bcast_hit = ENQ.valid && ENQ.bcast && (|dst_paused); // [R13]

    logic [PORTS-1:0] pause_event;
    generate
        for (g = 0; g < PORTS; g++) begin : g_evt
            wire cond = (omega == '0)
                || ((omega <= entry_level) && resv_zero[g])
                || (any_paused && resv_zero[g]); // [R6]
            assign pause_event[g] = ENQ.valid && ENQ.src[g] && (cond || bcast_hit); // [R6] [R13]
        end
    endgenerate

    wire leave = omega > resume_threshold; // [R7]
    wire [PORTS-1:0] next_pause = leave ? '0 : (PAUSE_WINDOW | pause_event); // [R7]
    wire [PORTS-1:0] next_cong = {PORTS{any_paused}} & resv_zero;
    wire drop_active = |(DROP_ENABLE & PAUSE_WINDOW);

    always_ff @(posedge CLK) begin
        if (SRST || cfg_state != ST_RUN) begin
            PAUSE_WINDOW <= '0;
            PAUSE_FRAME_REQ <= '0;
            PAUSE_TIME <= '0;
            FORCE_COLLISION <= '0;
            CONGESTED <= '0;
            BCAST_DROP <= 1'b0;
            RESERVE_TOTAL <= '0;
            VIRTUAL_FREE <= '0;
        end else begin
            PAUSE_WINDOW <= next_pause;
            PAUSE_FRAME_REQ <= pause_event; // [R15]
            PAUSE_TIME <= MAX_PAUSE; // [R15]
            FORCE_COLLISION <= HALF_DUPLEX & NON_LOCAL & PAUSE_WINDOW; // [R16]
            CONGESTED <= next_cong;
            BCAST_DROP <= drop_active; // [R14]
            RESERVE_TOTAL <= psi;
            VIRTUAL_FREE <= omega;
        end
    end
endmodule
`default_nettype wire

// ===== verif/switch_congestion_thresholds_checker.sv
// Purpose: Port-level checks of the congestion block
// Assumes: 256KB memory code, reserve 10, resume 87, rmax 4
// Notes: Relations start three edges after reset release
`default_nettype none
module switch_congestion_thresholds_checker import cong_pkg::*; #(parameter int PORTS = NPORT) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [PORTS*QW-1:0] QUEUE_LEN,
    input wire logic [CW-1:0] FREE_COUNT,
    input wire enq_t ENQ,
    input wire logic [PORTS-1:0] HALF_DUPLEX,
    input wire logic [PORTS-1:0] NON_LOCAL,
    input wire logic [PORTS-1:0] DROP_ENABLE,
    input wire logic [PORTS-1:0] PAUSE_WINDOW,
    input wire logic [PORTS-1:0] PAUSE_FRAME_REQ,
    input wire logic [15:0] PAUSE_TIME,
    input wire logic [PORTS-1:0] FORCE_COLLISION,
    input wire logic [PORTS-1:0] CONGESTED,
    input wire logic BCAST_DROP,
    input wire logic [CW-1:0] RESERVE_TOTAL,
    input wire logic [CW-1:0] VIRTUAL_FREE
);
    localparam logic [CW-1:0] C0 = 10'h00a, THR = 10'h061, RM = 10'h004;
    logic [1:0] age;
    always_ff @(posedge CLK) age <= SRST ? 2'h0 : age + {1'b0, age != 2'h3};
    wire logic run = age == 2'h3;
    function automatic logic [CW-1:0] psi(input logic [PORTS*QW-1:0] q);
        logic [CW-1:0] s = '0;
        for (int k = 0; k < PORTS; k++) s += (q[k*QW+:QW] >= RM) ? '0 : RM - q[k*QW+:QW];
        return s;
    endfunction
    function automatic logic [PORTS-1:0] rzero(input logic [PORTS*QW-1:0] q);
        logic [PORTS-1:0] z = '0;
        for (int k = 0; k < PORTS; k++) z[k] = (q[k*QW+:QW] >= RM);
        return z;
    endfunction
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    sequence src_hit; (PAUSE_WINDOW & PAUSE_FRAME_REQ & $past(ENQ.src)) == $past(ENQ.src); endsequence
    vfree_calc_a: assert property (run |-> VIRTUAL_FREE ==
        ($past(FREE_COUNT) > C0 ? $past(FREE_COUNT) - C0 : '0)) else $error("vfree");
    rsv_sum_a: assert property (run |-> RESERVE_TOTAL == psi($past(QUEUE_LEN))) else $error("psi");
    pause_time_a: assert property (run |-> PAUSE_TIME == 16'hffff) else $error("ptime");
    starve_pause_a: assert property (run && ENQ.valid && FREE_COUNT <= C0 |=> src_hit) else $error("starve");
    bcast_pause_a: assert property (run && ENQ.valid && ENQ.bcast && (ENQ.dst & PAUSE_WINDOW) != '0
        && FREE_COUNT <= THR |=> src_hit) else $error("bcast");
    leave_all_a: assert property (run && FREE_COUNT > THR |=> PAUSE_WINDOW == '0) else $error("leave");
    collide_a: assert property (run |-> FORCE_COLLISION == $past(HALF_DUPLEX & NON_LOCAL & PAUSE_WINDOW))
        else $error("coll");
    drop_win_a: assert property (run |-> BCAST_DROP == $past(|(DROP_ENABLE & PAUSE_WINDOW))) else $error("drop");
    congest_win_a: assert property (run |-> CONGESTED ==
        ($past(|PAUSE_WINDOW) ? rzero($past(QUEUE_LEN)) : '0)) else $error("congested");
endmodule
bind switch_congestion_thresholds switch_congestion_thresholds_checker #(.PORTS(PORTS)) u_chk (.CLK(CLK), .SRST(SRST),
    .QUEUE_LEN(QUEUE_LEN), .FREE_COUNT(FREE_COUNT), .ENQ(ENQ), .HALF_DUPLEX(HALF_DUPLEX), .NON_LOCAL(NON_LOCAL),
    .DROP_ENABLE(DROP_ENABLE), .PAUSE_WINDOW(PAUSE_WINDOW), .PAUSE_FRAME_REQ(PAUSE_FRAME_REQ), .PAUSE_TIME(PAUSE_TIME),
    .FORCE_COLLISION(FORCE_COLLISION), .CONGESTED(CONGESTED), .BCAST_DROP(BCAST_DROP), .RESERVE_TOTAL(RESERVE_TOTAL),
    .VIRTUAL_FREE(VIRTUAL_FREE));
`default_nettype wire

// ===== verif/mac_model.sv
// Purpose: Transmit MAC stand-in counting pause frames
// Assumes: One frame per request pulse
// Notes: Counts only frames with the maximum pause time
`default_nettype none
module mac_model import cong_pkg::*; (
    input wire logic CLK,
    input wire logic [NPORT-1:0] PAUSE_FRAME_REQ,
    input wire logic [15:0] PAUSE_TIME,
    output logic [CW-1:0] FRAMES
);
    timeunit 1ns;
    timeprecision 1ns;
    initial FRAMES = '0;
    always @(posedge CLK) FRAMES <= FRAMES + CW'($countones(PAUSE_FRAME_REQ & {NPORT{PAUSE_TIME == 16'hffff}}));
endmodule
`default_nettype wire

// ===== verif/switch_congestion_thresholds_tb_top.sv
// Purpose: Self-checking bench of the congestion block
// Assumes: 256KB memory code throughout
// Notes: Random phase, then pause window corners
`default_nettype none
module switch_congestion_thresholds_tb_top import cong_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK, SRST, BCAST_DROP;
    logic [NPORT*QW-1:0] QUEUE_LEN;
    logic [CW-1:0] FREE_COUNT, RESERVE_TOTAL, VIRTUAL_FREE, frames, base;
    logic [NPORT-1:0] HALF_DUPLEX, NON_LOCAL, DROP_ENABLE, PAUSE_WINDOW, PAUSE_FRAME_REQ, FORCE_COLLISION, CONGESTED;
    logic [15:0] PAUSE_TIME;
    enq_t ENQ;
    int failures, check_count, cyc;
    switch_congestion_thresholds u_switch_congestion_thresholds (.CLK(CLK), .SRST(SRST), .MEM_SIZE(MEM_256K),
        .QUEUE_LEN(QUEUE_LEN), .FREE_COUNT(FREE_COUNT), .ENQ(ENQ), .HALF_DUPLEX(HALF_DUPLEX), .NON_LOCAL(NON_LOCAL),
        .DROP_ENABLE(DROP_ENABLE), .PAUSE_WINDOW(PAUSE_WINDOW), .PAUSE_FRAME_REQ(PAUSE_FRAME_REQ),
        .PAUSE_TIME(PAUSE_TIME), .FORCE_COLLISION(FORCE_COLLISION), .CONGESTED(CONGESTED), .BCAST_DROP(BCAST_DROP),
        .RESERVE_TOTAL(RESERVE_TOTAL), .VIRTUAL_FREE(VIRTUAL_FREE));
    mac_model u_mac_model (.CLK(CLK), .PAUSE_FRAME_REQ(PAUSE_FRAME_REQ), .PAUSE_TIME(PAUSE_TIME), .FRAMES(frames));
    function automatic logic [CW-1:0] exp_vf(input logic [CW-1:0] f);
        return f > 10'h00a ? f - 10'h00a : 10'h000;
    endfunction
    task automatic cmp_n(input logic [CW-1:0] got, input logic [CW-1:0] want);
        check_count++;
        if (got !== want) begin
            failures++;
            $display("BAD %0t %h %h", $time, got, want);
        end
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic step(input logic [CW-1:0] f, input logic [NPORT-1:0] s, input logic [NPORT-1:0] d, input logic b);
        @(posedge CLK);
        FREE_COUNT <= f;
        ENQ <= '{valid: |s, src: s, dst: d, bcast: b};
        @(posedge CLK);
        ENQ.valid <= 1'b0;
        @(negedge CLK);
        cmp_n(VIRTUAL_FREE, exp_vf(f));
    endtask
    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            conclude;
        end
    end
    initial begin
        SRST = 1'b1;
        QUEUE_LEN = '0;
        FREE_COUNT = '0;
        ENQ = '0;
        {HALF_DUPLEX, NON_LOCAL, DROP_ENABLE} = '0;
        void'($urandom(32'hd18e7fdf));
        repeat (12) @(posedge CLK);
        SRST <= 1'b0;
        repeat (4) @(posedge CLK);
        for (int i = 0; i < 200; i++) begin
            for (int k = 0; k < NPORT; k++) QUEUE_LEN[k*QW+:QW] <= QW'($urandom_range(6));
            {HALF_DUPLEX, NON_LOCAL, DROP_ENABLE} <= 30'($urandom);
            step(CW'($urandom_range(160)), NPORT'(1 << $urandom_range(9)), NPORT'($urandom), 1'($urandom));
        end
        QUEUE_LEN <= '0;
        step(10'h0c8, '0, '0, 1'b0);
        cmp_n(PAUSE_WINDOW, '0);
        base = frames;
        step(10'h00a, 10'h001, '0, 1'b0);
        cmp_n(PAUSE_WINDOW & PAUSE_FRAME_REQ, 10'h001);
        step(10'h061, '0, '0, 1'b0);
        cmp_n(PAUSE_WINDOW | PAUSE_FRAME_REQ, 10'h001);
        step(10'h062, '0, '0, 1'b0);
        cmp_n(PAUSE_WINDOW, '0);
        step(10'h00a, 10'h002, '0, 1'b0);
        step(10'h03c, 10'h008, 10'h002, 1'b0);
        cmp_n(PAUSE_WINDOW, 10'h002);
        step(10'h03c, 10'h004, 10'h002, 1'b1);
        cmp_n(PAUSE_WINDOW & PAUSE_FRAME_REQ, 10'h004);
        @(negedge CLK);
        cmp_n(frames - base, 10'h003);
        conclude;
    end
endmodule
`default_nettype wire
